// [hw/tcc_pkg.sv]
// Package for the 16-bit timer with two input-capture channels.
// Assumes an APB master with 32-bit data; registers use the low byte of each word.
package tcc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_CAP1_HI  = 8'h0c;
  localparam logic [7:0] OFF_CAP1_LO  = 8'h10;
  localparam logic [7:0] OFF_CNT_HI   = 8'h14;
  localparam logic [7:0] OFF_CNT_LO   = 8'h18;
  localparam logic [7:0] OFF_ALT_HI   = 8'h1c;
  localparam logic [7:0] OFF_ALT_LO   = 8'h20;
  localparam logic [7:0] OFF_CAP2_HI  = 8'h24;
  localparam logic [7:0] OFF_CAP2_LO  = 8'h28;

  // Control one fields
  localparam int unsigned C1_CAP_IE = 7;
  localparam int unsigned C1_OVF_IE = 5;
  localparam int unsigned C1_EDGE1  = 1;

  // Control two fields
  localparam int unsigned C2_PWM     = 5;
  localparam int unsigned C2_OPM     = 4;
  localparam int unsigned C2_CS_LO   = 2;
  localparam int unsigned C2_EDGE2   = 1;
  localparam int unsigned C2_EXT_EDG = 0;

  // Status fields
  localparam int unsigned ST_CAP1 = 7;
  localparam int unsigned ST_OVF  = 5;
  localparam int unsigned ST_CAP2 = 4;

  // Reset and limit values
  localparam logic [15:0] CNT_RESET  = 16'hfffc;
  localparam logic [15:0] CNT_TOP    = 16'hffff;
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  // Counter clock choice
  typedef enum logic [1:0] {
    TCC_DIV2 = 2'b00,
    TCC_DIV4 = 2'b01,
    TCC_DIV8 = 2'b10,
    TCC_EXT  = 2'b11
  } tcc_clk_sel_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tcc_apb_req_t;

endpackage

// [hw/tcc_timer.sv]
// 16-bit free-running timer with two input-capture channels, APB slave.
// Assumes capture and external clock pins are asynchronous to clk_i.
//
// Functional notes
// - Sixteen-bit up-counter, primary and alternate read pairs
// - Low count byte write reloads fffc
// - Reset and only reload value is fffc
// - Counter advances at clock over 2, 4, 8
// - Clock select 11 picks external clock pin
// - External edge select picks active transition
// - External increments aligned to core clock edge
// - High byte read latches low byte
// - Lone low byte read returns live value
// - Rollover ffff to 0000 sets overflow flag
// - Overflow request needs enable and clear mask
// - Status read then low count access clears overflow
// - Alternate low byte never clears overflow
// - Counter runs in wait, holds in halt
// - Active capture edge copies count, sets flag
// - Capture registers ignore writes
// - Channel edge selects in control one, two
// - One capture enable gates both flags
// - Status read then low capture access clears flag
// - High capture read blocks capture until low read
// - New capture overwrites previous value
// - One-pulse or PWM leaves only channel two
// - Capture pin two always feeds capture logic, pin one only outside one-pulse and PWM
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps

module tcc_timer (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  // APB slave
  input  tcc_pkg::tcc_apb_req_t apb_i,
  output logic [31:0]          prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  // Pins
  input  wire logic [1:0]      capture_pin_i,
  input  wire logic            ext_clock_pin_i,
  // System
  input  wire logic            global_irq_mask_i,
  input  wire logic            halt_i,
  output logic                 timer_irq_o
);

  // Access phase at a given offset
  function automatic logic acc_at(input tcc_pkg::tcc_apb_req_t r, input logic [7:0] off);
    return r.psel & r.penable & (r.paddr == off);
  endfunction

  // Prescaler tick for the divided clock
  function automatic logic div_tick(input tcc_pkg::tcc_clk_sel_t cs, input logic [2:0] p);
    case (cs)
      tcc_pkg::TCC_DIV2: div_tick = p[0];
      tcc_pkg::TCC_DIV4: div_tick = &p[1:0];
      tcc_pkg::TCC_DIV8: div_tick = &p;
      default:           div_tick = 1'b0;
    endcase
  endfunction

  logic [7:0]  ctrl_one_r;
  logic [7:0]  ctrl_two_r;
  logic [15:0] cnt_r;
  logic [15:0] snap_r;
  logic [7:0]  lo_latch_r;
  logic        seq_r;
  logic [2:0]  flag_r;
  logic [2:0]  arm_r;
  logic [1:0]  inh_r;
  logic [15:0] cap_r [2];
  logic [2:0]  pre_r;
  logic [2:0]  s1_r;
  logic [2:0]  s2_r;
  logic [2:0]  s3_r;
  logic [2:0]  stab_r;
  logic [31:0] prdata_r;
  logic        err_r;

  logic        setup;
  logic        rd_acc;
  logic        wr_acc;
  logic [2:0]  agree;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic        ext_ev;
  logic        inc;
  logic        cnt_wr;
  logic        ovf_ev;
  logic        wave_mode;
  logic [1:0]  cap_ev;
  logic [2:0]  clr;
  logic [7:0]  rd_byte;
  logic        mapped;
  tcc_pkg::tcc_clk_sel_t cs;

  assign setup  = apb_i.psel & ~apb_i.penable;
  assign rd_acc = ~apb_i.pwrite;
  assign wr_acc = apb_i.pwrite;
  assign cs     = tcc_pkg::tcc_clk_sel_t'(ctrl_two_r[tcc_pkg::C2_CS_LO +: 2]);

  // Pin synchronisers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
    end else begin
      s1_r <= {ext_clock_pin_i, capture_pin_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accepted pin level follows once second and third stages agree
  assign agree = ~(s2_r ^ s3_r);
  assign rise  = agree & s3_r & ~stab_r;
  assign fall  = agree & ~s3_r & stab_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stab_r <= 3'h0;
    end else begin
      stab_r <= (s3_r & agree) | (stab_r & ~agree);
    end
  end

  // Prescaler
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  assign ext_ev = ctrl_two_r[tcc_pkg::C2_EXT_EDG] ? rise[2] : fall[2];
  assign inc    = halt_i ? 1'b0 :
                  (cs == tcc_pkg::TCC_EXT) ? ext_ev :
                  div_tick(cs, pre_r);
  assign cnt_wr = wr_acc & (acc_at(apb_i, tcc_pkg::OFF_CNT_LO) |
                            acc_at(apb_i, tcc_pkg::OFF_ALT_LO));
  assign ovf_ev = inc & ~cnt_wr & (cnt_r == tcc_pkg::CNT_TOP);

  // Free-running counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= tcc_pkg::CNT_RESET;
    end else if (cnt_wr) begin
      cnt_r <= tcc_pkg::CNT_RESET;
    end else if (inc) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Control registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_one_r <= tcc_pkg::CTRL_RESET;
      ctrl_two_r <= tcc_pkg::CTRL_RESET;
    end else if (wr_acc) begin
      if (acc_at(apb_i, tcc_pkg::OFF_CTRL_ONE)) begin
        ctrl_one_r <= apb_i.pwdata[7:0];
      end
      if (acc_at(apb_i, tcc_pkg::OFF_CTRL_TWO)) begin
        ctrl_two_r <= apb_i.pwdata[7:0];
      end
    end
  end

  // Two-byte read sequence shared by both count pairs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_r      <= 1'b0;
      lo_latch_r <= 8'h00;
    end else if (rd_acc & (acc_at(apb_i, tcc_pkg::OFF_CNT_HI) |
                           acc_at(apb_i, tcc_pkg::OFF_ALT_HI))) begin
      if (!seq_r) begin
        seq_r      <= 1'b1;
        lo_latch_r <= snap_r[7:0];
      end
    end else if (rd_acc & (acc_at(apb_i, tcc_pkg::OFF_CNT_LO) |
                           acc_at(apb_i, tcc_pkg::OFF_ALT_LO))) begin
      seq_r <= 1'b0;
    end
  end

  // Captures
  assign wave_mode = ctrl_two_r[tcc_pkg::C2_OPM] | ctrl_two_r[tcc_pkg::C2_PWM];
  assign cap_ev[0] = (ctrl_one_r[tcc_pkg::C1_EDGE1] ? rise[0] : fall[0]) &
                     ~inh_r[0] & ~wave_mode;
  assign cap_ev[1] = (ctrl_two_r[tcc_pkg::C2_EDGE2] ? rise[1] : fall[1]) &
                     ~inh_r[1];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_r[0] <= 16'h0000;
      cap_r[1] <= 16'h0000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_ev[i]) begin
          cap_r[i] <= cnt_r;
        end
      end
    end
  end

  // Capture inhibit between high and low byte reads
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inh_r <= 2'b00;
    end else if (rd_acc) begin
      if (acc_at(apb_i, tcc_pkg::OFF_CAP1_HI)) inh_r[0] <= 1'b1;
      if (acc_at(apb_i, tcc_pkg::OFF_CAP1_LO)) inh_r[0] <= 1'b0;
      if (acc_at(apb_i, tcc_pkg::OFF_CAP2_HI)) inh_r[1] <= 1'b1;
      if (acc_at(apb_i, tcc_pkg::OFF_CAP2_LO)) inh_r[1] <= 1'b0;
    end
  end

  // Flags: bit 0 capture one, bit 1 capture two, bit 2 overflow
  assign clr[0] = arm_r[0] & acc_at(apb_i, tcc_pkg::OFF_CAP1_LO);
  assign clr[1] = arm_r[1] & acc_at(apb_i, tcc_pkg::OFF_CAP2_LO);
  assign clr[2] = arm_r[2] & acc_at(apb_i, tcc_pkg::OFF_CNT_LO);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_r <= 3'h0;
    end else begin
      flag_r <= {ovf_ev, cap_ev} | (flag_r & ~clr);
    end
  end

  // Status read arms the clear of each flag then set
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arm_r <= 3'h0;
    end else if (rd_acc & acc_at(apb_i, tcc_pkg::OFF_STATUS)) begin
      arm_r <= flag_r;
    end else begin
      arm_r <= arm_r & ~clr;
    end
  end

  // Read data multiplexer
  always_comb begin
    rd_byte = 8'h00;
    mapped  = 1'b1;
    case (apb_i.paddr)
      tcc_pkg::OFF_CTRL_ONE: rd_byte = ctrl_one_r;
      tcc_pkg::OFF_CTRL_TWO: rd_byte = ctrl_two_r;
      tcc_pkg::OFF_STATUS: begin
        rd_byte[tcc_pkg::ST_CAP1] = flag_r[0];
        rd_byte[tcc_pkg::ST_CAP2] = flag_r[1];
        rd_byte[tcc_pkg::ST_OVF]  = flag_r[2];
      end
      tcc_pkg::OFF_CAP1_HI: rd_byte = cap_r[0][15:8];
      tcc_pkg::OFF_CAP1_LO: rd_byte = cap_r[0][7:0];
      tcc_pkg::OFF_CAP2_HI: rd_byte = cap_r[1][15:8];
      tcc_pkg::OFF_CAP2_LO: rd_byte = cap_r[1][7:0];
      tcc_pkg::OFF_CNT_HI,
      tcc_pkg::OFF_ALT_HI:  rd_byte = cnt_r[15:8];
      tcc_pkg::OFF_CNT_LO,
      tcc_pkg::OFF_ALT_LO:  rd_byte = seq_r ? lo_latch_r : cnt_r[7:0];
      default:              mapped  = 1'b0;
    endcase
  end

  // Read data and count snapshot taken in the setup cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_r <= 32'h0000_0000;
      snap_r   <= tcc_pkg::CNT_RESET;
      err_r    <= 1'b0;
    end else if (setup) begin
      prdata_r <= {24'h00_0000, rd_byte};
      snap_r   <= cnt_r;
      err_r    <= ~mapped;
    end
  end

  assign prdata_o    = prdata_r;
  assign pready_o    = 1'b1;
  assign pslverr_o   = apb_i.psel & apb_i.penable & err_r;
  assign timer_irq_o = ~global_irq_mask_i &
                       ((flag_r[2] & ctrl_one_r[tcc_pkg::C1_OVF_IE]) |
                        ((|flag_r[1:0]) & ctrl_one_r[tcc_pkg::C1_CAP_IE]));

  // Checks
  cnt_reload_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cnt_wr |=> cnt_r == tcc_pkg::CNT_RESET)
    else $error("count not reloaded after low byte write");

  ovf_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (inc && !cnt_wr && cnt_r == tcc_pkg::CNT_TOP) |=> flag_r[2] && cnt_r == 16'h0000)
    else $error("rollover did not set overflow");

  ovf_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (arm_r[2] && acc_at(apb_i, tcc_pkg::OFF_CNT_LO) && !ovf_ev) |=> !flag_r[2])
    else $error("armed low count access left overflow set");

  ext_edge_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cs == tcc_pkg::TCC_EXT && ctrl_two_r[tcc_pkg::C2_EXT_EDG] && rise[2] &&
     !halt_i && !cnt_wr) |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("active external edge did not advance count");

  cap_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (arm_r[1] && acc_at(apb_i, tcc_pkg::OFF_CAP2_LO) && !cap_ev[1]) |=> !flag_r[1])
    else $error("armed low capture access left flag set");

  irq_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    global_irq_mask_i |-> !timer_irq_o)
    else $error("interrupt raised while masked");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (seq_r && !(rd_acc && (acc_at(apb_i, tcc_pkg::OFF_CNT_LO) ||
                           acc_at(apb_i, tcc_pkg::OFF_ALT_LO))))
    |=> seq_r && $stable(lo_latch_r))
    else $error("latched low byte changed mid sequence");

  alt_noclr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (flag_r[2] && acc_at(apb_i, tcc_pkg::OFF_ALT_LO)) |=> flag_r[2])
    else $error("alternate access cleared overflow");

  halt_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (halt_i && !cnt_wr) |=> $stable(cnt_r))
    else $error("counter moved in halt");

  cap_inhibit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    inh_r[0] |=> $stable(cap_r[0]))
    else $error("capture one updated while inhibited");

  cap_wave_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wave_mode && !flag_r[0]) |=> !flag_r[0] && $stable(cap_r[0]))
    else $error("channel one captured in waveform mode");

  cap_value_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cap_ev[1] |=> cap_r[1] == $past(cnt_r) && flag_r[1])
    else $error("capture two value or flag wrong");

  div2_rate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cs == tcc_pkg::TCC_DIV2 && !halt_i && !cnt_wr && inc) |=> !inc)
    else $error("divide by two ticked on consecutive cycles");

endmodule // tcc_timer

// [testbench/tcc_pin_model.sv]
// Far side pin model: two capture pins and the external counter clock.
// Assumes the bench calls flip; pins change by nba just after a rising clk edge.
`timescale 1ns/1ps
module tcc_pin_model (
  // Clock
  input  wire logic  clk_i,
  // Pins
  output logic [1:0] capture_pin_o,
  output logic       ext_clock_pin_o
);
  initial begin
    capture_pin_o   = 2'b00;
    ext_clock_pin_o = 1'b0;
  end

  // One edge on pin 0/1 (capture) or 2 (ext clock), then eight quiet clocks
  task automatic flip(input int unsigned idx);
    @(posedge clk_i);
    if (idx < 2) capture_pin_o[idx] <= ~capture_pin_o[idx];
    else ext_clock_pin_o <= ~ext_clock_pin_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // tcc_pin_model

// [testbench/testbench.sv]
// Self-checking bench for the capture timer over APB.
// Assumes tcc_pin_model drives the pins and the clock runs at 200 MHz.
`timescale 1ns/1ps
module testbench;
  logic                  clk_i;
  logic                  rst_b_i;
  tcc_pkg::tcc_apb_req_t req;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [1:0]            cap_pin;
  logic                  ext_pin;
  logic                  mask;
  logic                  halt;
  logic                  irq;
  logic [7:0]            v;
  logic [7:0]            l;
  logic                  e;
  int                    fails;
  int                    checks_done;
  int                    n;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  tcc_timer uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .apb_i(req), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .capture_pin_i(cap_pin),
    .ext_clock_pin_i(ext_pin), .global_irq_mask_i(mask), .halt_i(halt),
    .timer_irq_o(irq));
  tcc_pin_model pins (.clk_i(clk_i), .capture_pin_o(cap_pin), .ext_clock_pin_o(ext_pin));

  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One APB transfer; read data and error taken at the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk_i);
    req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      report_and_stop();
    end
    v = prdata[7:0];
    e = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), x, v);
  endtask

  task automatic cnt(input logic [15:0] x);
    rdc(tcc_pkg::OFF_CNT_HI, x[15:8]);
    rdc(tcc_pkg::OFF_CNT_LO, x[7:0]);
  endtask

  task automatic irq_is(input logic x);
    @(negedge clk_i);
    chk("irq", {7'h00, x}, {7'h00, irq});
  endtask

  task automatic run(input int c);
    halt <= 1'b0;
    repeat (c) @(posedge clk_i);
    halt <= 1'b1;
  endtask

  task automatic pulse(input int unsigned i);
    pins.flip(i);
    pins.flip(i);
  endtask

  initial begin
    req         = '0;
    rst_b_i     = 1'b0;
    halt        = 1'b1;
    mask        = 1'b0;
    fails       = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    cnt(16'hfffc);
    rdc(tcc_pkg::OFF_ALT_HI, 8'hff);
    rdc(tcc_pkg::OFF_ALT_LO, 8'hfc);
    rdc(tcc_pkg::OFF_CTRL_TWO, 8'h00);
    apb(1'b0, 8'h30, 8'h00);
    chk("pslverr", 8'h01, {7'h00, e});
    // Overflow flag, request gating and clearing
    apb(1'b1, tcc_pkg::OFF_CTRL_ONE, 8'h20);
    run(40);
    rdc(tcc_pkg::OFF_STATUS, 8'h20);
    irq_is(1'b1);
    @(posedge clk_i);
    mask <= 1'b1;
    irq_is(1'b0);
    apb(1'b0, tcc_pkg::OFF_ALT_LO, 8'h00);
    rdc(tcc_pkg::OFF_STATUS, 8'h20);
    apb(1'b0, tcc_pkg::OFF_CNT_LO, 8'h00);
    rdc(tcc_pkg::OFF_STATUS, 8'h00);
    // Two-byte read sequence
    apb(1'b0, tcc_pkg::OFF_CNT_LO, 8'h00);
    l = v;
    apb(1'b0, tcc_pkg::OFF_CNT_HI, 8'h00);
    run(30);
    apb(1'b0, tcc_pkg::OFF_CNT_HI, 8'h00);
    rdc(tcc_pkg::OFF_CNT_LO, l);
    apb(1'b0, tcc_pkg::OFF_ALT_LO, 8'h00);
    chk("live", 8'h00, {7'h00, v === l});
    rdc(tcc_pkg::OFF_CNT_LO, v);
    for (int i = 0; i < 2; i++) begin
      run(10);
      apb(1'b1, i ? tcc_pkg::OFF_CNT_LO : tcc_pkg::OFF_ALT_LO, 8'h00);
      cnt(16'hfffc);
    end
    // Prescaler rates
    for (int d = 0; d < 3; d++) begin
      apb(1'b1, tcc_pkg::OFF_CTRL_TWO, 8'(d << 2));
      apb(1'b1, tcc_pkg::OFF_CNT_LO, 8'h00);
      run(48);
      apb(1'b0, tcc_pkg::OFF_CNT_HI, 8'h00);
      l = v;
      apb(1'b0, tcc_pkg::OFF_CNT_LO, 8'h00);
      n = int'(16'({l, v} - tcc_pkg::CNT_RESET)) - (48 >> (d + 1));
      chk("rate", 8'h01, {7'h00, n >= -1 && n <= 1});
    end
    apb(1'b0, tcc_pkg::OFF_STATUS, 8'h00);
    apb(1'b0, tcc_pkg::OFF_CNT_LO, 8'h00);
    // External clock, both active edges
    halt <= 1'b0;
    for (int x = 1; x >= 0; x--) begin
      apb(1'b1, tcc_pkg::OFF_CTRL_TWO, {7'h06, x[0]});
      apb(1'b1, tcc_pkg::OFF_CNT_LO, 8'h00);
      n = 0;
      for (int k = 0; k < 2; k++) begin
        pins.flip(2);
        n += ((k == 0) == (x == 1));
        cnt(16'hfffc + 16'(n));
      end
    end
    // Input capture on channel one
    mask <= 1'b0;
    apb(1'b1, tcc_pkg::OFF_CTRL_ONE, 8'h82);
    apb(1'b1, tcc_pkg::OFF_CTRL_TWO, 8'h0e);
    pulse(0);
    rdc(tcc_pkg::OFF_STATUS, 8'h80);
    irq_is(1'b1);
    rdc(tcc_pkg::OFF_CAP1_HI, 8'hff);
    rdc(tcc_pkg::OFF_CAP1_LO, 8'hfd);
    rdc(tcc_pkg::OFF_STATUS, 8'h00);
    apb(1'b1, tcc_pkg::OFF_CAP1_LO, 8'h55);
    rdc(tcc_pkg::OFF_CAP1_LO, 8'hfd);
    apb(1'b0, tcc_pkg::OFF_CAP1_HI, 8'h00);
    pulse(2);
    pulse(0);
    rdc(tcc_pkg::OFF_STATUS, 8'h00);
    rdc(tcc_pkg::OFF_CAP1_LO, 8'hfd);
    pulse(0);
    rdc(tcc_pkg::OFF_STATUS, 8'h80);
    rdc(tcc_pkg::OFF_CAP1_LO, 8'hfe);
    // One-pulse and PWM leave channel two only
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, tcc_pkg::OFF_CTRL_TWO, m ? 8'h2e : 8'h1e);
      pulse(0);
      pulse(1);
      rdc(tcc_pkg::OFF_STATUS, 8'h10);
      rdc(tcc_pkg::OFF_CAP2_LO, 8'hfe);
    end
    report_and_stop();
  end
endmodule // testbench
